// *** hw/css_device.sv ***
// Card supply sequencer: supply selection, ready timing, checks and deactivation.
//
// Summary of operation
// - Chip select gates host control inputs except power-down.
// - Either supply command falling starts activation.
// - Single command picks 5 V or 3 V.
// - Both falling within 400 ns picks 1.8 V.
// - Edge triggered; late second command ignored.
// - Card reset follows host reset when enabled.
// - Card clock comes only from host clock.
// - Ready after supply good for 20 us.
// - Check ready at 510 us, else deactivate.
// - Temperature, removal, release deactivate during check.
// - Idle interrupt line shows card presence.
// - Session fault drives interrupt low, deactivates.
// - Supply supervisor faults force deactivation; card supply only once qualified.
// - Card over-current is a deactivation fault.
// - Die over-temperature is a deactivation fault.
// - Power-down request enters low-power state.
// - Chip select low holds latched inputs.
// - Card signals stay low until ready.
// - Outside a card session faults do not reach the interrupt line; vdd and over-temperature faults block activation.
// - Power-down only while card deactivated.
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/10ps
module css_device
  import css_pkg::*;
#(
  parameter int CHECK_CYC = CSS_CHECK_CYC
)(
  input  wire logic       core_clk_i,
  input  wire logic       reset_n_i,
  css_link_if.device      link,
  input  wire logic       card_present_i,
  input  wire logic       vdd_fault_i,
  input  wire logic       regulator_input_supply_fault_i,
  input  wire logic       card_supply_ok_i,
  input  wire logic       over_current_i,
  input  wire logic       over_temp_i,
  output logic [1:0]      vcc_select_o,
  output logic            vcc_enable_o,
  output logic            card_reset_o,
  output logic            card_clock_o,
  output logic            low_power_o
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_PDOWN, ST_RECOVER, ST_PAIR, ST_RAMP, ST_SESSION, ST_DEACT
  } css_state_t;

  css_state_t            state;
  logic [CSS_SY_W-1:0]   sync_raw;
  logic [CSS_SY_W-1:0]   sync_a;
  logic [CSS_SY_W-1:0]   sync_b;
  logic                  lat_lo_n;
  logic                  lat_hi_n;
  logic                  lat_rst;
  logic                  lat_clk;
  logic                  prev_lo_n;
  logic                  prev_hi_n;
  logic                  fall_lo;
  logic                  fall_hi;
  logic                  first_lo;
  logic [CSS_WIN_W-1:0]  win_cnt;
  logic [CSS_CNT_W-1:0]  chk_cnt;
  logic [CSS_QUAL_W-1:0] qual_cnt;
  logic                  ready_int;
  logic                  fault_any;
  logic                  cmd_any_low;
  logic                  abort_act;
  logic                  fault_flag;
  logic [1:0]            vsel;
  logic                  off_n;
  logic                  next_off_n;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Every pin and analog flag is asynchronous, so each passes two flops.
  assign sync_raw = {over_temp_i, over_current_i, card_supply_ok_i,
                     regulator_input_supply_fault_i, vdd_fault_i, card_present_i,
                     link.power_down_request, link.host_card_clock_in,
                     link.host_card_reset_in, link.supply_cmd_high_voltage_n,
                     link.supply_cmd_low_voltage_n, link.chip_select};

  // Command bits reset high so that release of reset is not seen as a fall.
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      sync_a <= CSS_SY_RSTVAL;
      sync_b <= CSS_SY_RSTVAL;
    end
    else
    begin
      sync_a <= sync_raw;
      sync_b <= sync_a;
    end
  end

  // ----------------------------------------------------------------
  // Chip select latches and edge detection
  // ----------------------------------------------------------------
  // Latches follow the pins only while selected; power-down is not latched.
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      lat_lo_n <= 1'b1;
      lat_hi_n <= 1'b1;
      lat_rst  <= 1'b0;
      lat_clk  <= 1'b0;
    end
    else if (sync_b[CSS_SY_CS])
    begin
      lat_lo_n <= sync_b[CSS_SY_LO];
      lat_hi_n <= sync_b[CSS_SY_HI];
      lat_rst  <= sync_b[CSS_SY_RST];
      lat_clk  <= sync_b[CSS_SY_CLK];
    end
  end

  // Previous command levels for falling edge detection.
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      prev_lo_n <= 1'b1;
      prev_hi_n <= 1'b1;
    end
    else
    begin
      prev_lo_n <= lat_lo_n;
      prev_hi_n <= lat_hi_n;
    end
  end

  // Activation reacts to edges, so a command held low from before does nothing.
  assign fall_lo     = prev_lo_n & ~lat_lo_n;
  assign fall_hi     = prev_hi_n & ~lat_hi_n;
  assign cmd_any_low = ~lat_lo_n | ~lat_hi_n;

  // Supervisors, over-current and over-temperature all feed one fault term.
  // The card supply supervisor only counts once the supply was qualified.
  assign fault_any = sync_b[CSS_SY_VDD] | sync_b[CSS_SY_VPC]
                   | (ready_int & ~sync_b[CSS_SY_VOK])
                   | sync_b[CSS_SY_OC]
                   | sync_b[CSS_SY_OT];
  assign abort_act = ~sync_b[CSS_SY_PRES] | fault_any | ~cmd_any_low;

  // ----------------------------------------------------------------
  // Sequencer state machine
  // ----------------------------------------------------------------
  // A second fall outside the pair window is ignored; only ST_PAIR looks for it.
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      state      <= ST_IDLE;
      vsel       <= CSS_VSEL_NONE;
      first_lo   <= 1'b0;
      win_cnt    <= '0;
      chk_cnt    <= '0;
      fault_flag <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          chk_cnt    <= '0;
          win_cnt    <= '0;
          fault_flag <= 1'b0;
          if (sync_b[CSS_SY_PD] && !cmd_any_low)
            state <= ST_PDOWN;
          else if ((fall_lo || fall_hi) && sync_b[CSS_SY_PRES]
                   && !sync_b[CSS_SY_VDD] && !sync_b[CSS_SY_OT])
          begin
            if (fall_lo && fall_hi)
            begin
              vsel  <= CSS_VSEL_1V8;
              state <= ST_RAMP;
            end
            else
            begin
              first_lo <= fall_lo;
              state    <= ST_PAIR;
            end
          end
        end
        ST_PDOWN:
        begin
          chk_cnt <= '0;
          if (!sync_b[CSS_SY_PD])
            state <= ST_RECOVER;
        end
        ST_RECOVER:
        begin
          chk_cnt <= chk_cnt + 1'b1;
          if (chk_cnt == CSS_CNT_W'(CSS_RECOVER_CYC - 1))
            state <= ST_IDLE;
        end
        ST_PAIR:
        begin
          chk_cnt <= chk_cnt + 1'b1;
          win_cnt <= win_cnt + 1'b1;
          if (abort_act)
          begin
            fault_flag <= cmd_any_low;
            state      <= ST_DEACT;
          end
          else if (first_lo ? fall_hi : fall_lo)
          begin
            vsel  <= CSS_VSEL_1V8;
            state <= ST_RAMP;
          end
          else if (win_cnt == CSS_WIN_W'(CSS_PAIR_WIN_CYC - 1))
          begin
            vsel  <= first_lo ? CSS_VSEL_3V : CSS_VSEL_5V;
            state <= ST_RAMP;
          end
        end
        ST_RAMP:
        begin
          chk_cnt <= chk_cnt + 1'b1;
          if (abort_act)
          begin
            fault_flag <= cmd_any_low;
            state      <= ST_DEACT;
          end
          else if (chk_cnt == CSS_CNT_W'(CHECK_CYC - 1))
          begin
            fault_flag <= ~ready_int;
            state      <= ready_int ? ST_SESSION : ST_DEACT;
          end
        end
        ST_SESSION:
        begin
          if (!cmd_any_low)
            state <= ST_DEACT;
          else if (!sync_b[CSS_SY_PRES] || fault_any)
          begin
            fault_flag <= 1'b1;
            state      <= ST_DEACT;
          end
        end
        ST_DEACT:
        begin
          vsel <= CSS_VSEL_NONE;
          if (!cmd_any_low)
            state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Supply qualification
  // ----------------------------------------------------------------
  // Any dip of the supply restarts the count, so the good level is continuous.
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
      qual_cnt <= '0;
    else if (!vcc_enable_o || !sync_b[CSS_SY_VOK])
      qual_cnt <= '0;
    else if (qual_cnt != CSS_QUAL_W'(CSS_QUAL_CYC))
      qual_cnt <= qual_cnt + 1'b1;
  end

  assign ready_int = (qual_cnt == CSS_QUAL_W'(CSS_QUAL_CYC));

  // ----------------------------------------------------------------
  // Interrupt line
  // ----------------------------------------------------------------
  // In idle and power-down the line shows presence only; faults cannot reach it.
  always_comb
  begin
    case (state)
      ST_IDLE, ST_PDOWN:                next_off_n = sync_b[CSS_SY_PRES];
      ST_RECOVER:                       next_off_n = 1'b0;
      ST_PAIR, ST_RAMP, ST_SESSION:     next_off_n = 1'b1;
      ST_DEACT:                         next_off_n = ~fault_flag;
      default:                          next_off_n = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
      off_n <= 1'b0;
    else
      off_n <= next_off_n;
  end

  // ----------------------------------------------------------------
  // Card-side and link outputs
  // ----------------------------------------------------------------
  // Reset and clock are gated by ready; the clock is the host clock, undivided.
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      vcc_select_o <= CSS_VSEL_NONE;
      vcc_enable_o <= 1'b0;
      card_reset_o <= 1'b0;
      card_clock_o <= 1'b0;
      low_power_o  <= 1'b0;
    end
    else
    begin
      vcc_select_o <= vsel;
      vcc_enable_o <= (state == ST_RAMP) || (state == ST_SESSION);
      card_reset_o <= ready_int && vcc_enable_o && lat_rst;
      card_clock_o <= ready_int && vcc_enable_o && lat_clk;
      low_power_o  <= (state == ST_PDOWN);
    end
  end

  // Deselected device releases both open-drain lines.
  assign link.off_n_out = off_n;
  assign link.off_n_oe  = sync_b[CSS_SY_CS];
  assign link.ready_out = ready_int && vcc_enable_o;
  assign link.ready_oe  = sync_b[CSS_SY_CS];

endmodule

// *** inc/css_pkg.sv ***
// Shared constants for the card supply sequencer and its host controller.
package css_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CSS_CLK_KHZ      = 40000;
  localparam int CSS_PAIR_WIN_NS  = 400;
  localparam int CSS_QUAL_US      = 20;
  localparam int CSS_CHECK_US     = 510;
  localparam int CSS_RECOVER_US   = 10;
  // Longest window rounds down; least times round up.
  localparam int CSS_PAIR_WIN_CYC = (CSS_PAIR_WIN_NS * CSS_CLK_KHZ) / 1000000;
  localparam int CSS_QUAL_CYC     = (CSS_QUAL_US * CSS_CLK_KHZ + 999) / 1000;
  localparam int CSS_CHECK_CYC    = (CSS_CHECK_US * CSS_CLK_KHZ + 999) / 1000;
  localparam int CSS_RECOVER_CYC  = (CSS_RECOVER_US * CSS_CLK_KHZ + 999) / 1000;
  localparam int CSS_CNT_W        = 15;
  localparam int CSS_QUAL_W       = 10;
  localparam int CSS_WIN_W        = 5;

  // ----------------------------------------------------------------
  // Card supply selection codes
  // ----------------------------------------------------------------
  localparam logic [1:0] CSS_VSEL_NONE = 2'h0;
  localparam logic [1:0] CSS_VSEL_5V   = 2'h1;
  localparam logic [1:0] CSS_VSEL_3V   = 2'h2;
  localparam logic [1:0] CSS_VSEL_1V8  = 2'h3;

  // ----------------------------------------------------------------
  // Synchroniser bit positions and reset value
  // ----------------------------------------------------------------
  localparam int CSS_SY_CS   = 0;
  localparam int CSS_SY_LO   = 1;
  localparam int CSS_SY_HI   = 2;
  localparam int CSS_SY_RST  = 3;
  localparam int CSS_SY_CLK  = 4;
  localparam int CSS_SY_PD   = 5;
  localparam int CSS_SY_PRES = 6;
  localparam int CSS_SY_VDD  = 7;
  localparam int CSS_SY_VPC  = 8;
  localparam int CSS_SY_VOK  = 9;
  localparam int CSS_SY_OC   = 10;
  localparam int CSS_SY_OT   = 11;
  localparam int CSS_SY_W    = 12;
  localparam logic [CSS_SY_W-1:0] CSS_SY_RSTVAL = 12'h006;

  // ----------------------------------------------------------------
  // Host register map and fields
  // ----------------------------------------------------------------
  localparam int         CSS_AW        = 4;
  localparam int         CSS_DW        = 8;
  localparam logic [3:0] CSS_REG_CTRL  = 4'h0;
  localparam logic [3:0] CSS_REG_STAT  = 4'h1;
  localparam int         CSS_CT_CS     = 0;
  localparam int         CSS_CT_LO_N   = 1;
  localparam int         CSS_CT_HI_N   = 2;
  localparam int         CSS_CT_RST    = 3;
  localparam int         CSS_CT_CLKEN  = 4;
  localparam int         CSS_CT_PD     = 5;
  localparam logic [7:0] CSS_CTRL_RST  = 8'h06;
  localparam int         CSS_ST_OFF_N  = 0;
  localparam int         CSS_ST_RDY    = 1;
  localparam int         CSS_CLK_HALF  = 4;
  localparam int         CSS_DIV_W     = 3;

endpackage

// *** inc/css_link_if.sv ***
// Pin-level link between the host controller and the card supply sequencer.
`timescale 1ns/10ps
interface css_link_if;
  logic chip_select;
  logic supply_cmd_low_voltage_n;
  logic supply_cmd_high_voltage_n;
  logic host_card_reset_in;
  logic host_card_clock_in;
  logic power_down_request;
  logic off_n_out;
  logic off_n_oe;
  logic ready_out;
  logic ready_oe;
  logic off_n_line;
  logic ready_line;

  // Undriven lines float high through the host-side pull-ups.
  assign off_n_line = off_n_oe ? off_n_out : 1'b1;
  assign ready_line = ready_oe ? ready_out : 1'b1;

  modport device (
    input  chip_select, supply_cmd_low_voltage_n, supply_cmd_high_voltage_n,
    input  host_card_reset_in, host_card_clock_in, power_down_request,
    output off_n_out, off_n_oe, ready_out, ready_oe
  );
  modport host (
    output chip_select, supply_cmd_low_voltage_n, supply_cmd_high_voltage_n,
    output host_card_reset_in, host_card_clock_in, power_down_request,
    input  off_n_line, ready_line
  );
endinterface

// *** hw/css_host.sv ***
// Host controller end: register port driving the sequencer control pins.
`timescale 1ns/10ps
module css_host
  import css_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              reset_n_i,
  css_link_if.host               link,
  input  wire logic [CSS_AW-1:0] addr_i,
  input  wire logic [CSS_DW-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic [CSS_DW-1:0]      rdata_o
);

  logic [CSS_DW-1:0]    ctrl;
  logic [1:0]           st_a;
  logic [1:0]           st_b;
  logic [CSS_DIV_W-1:0] div_cnt;
  logic                 clk_out;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Both commands written low in one write fall together and ask for 1.8 V.
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
      ctrl <= CSS_CTRL_RST;
    else if (wr_i && addr_i == CSS_REG_CTRL)
      ctrl <= wdata_i;
  end

  // ----------------------------------------------------------------
  // Status synchroniser and read port
  // ----------------------------------------------------------------
  // Link lines are pins, so they pass two flops before software sees them.
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      st_a <= 2'h0;
      st_b <= 2'h0;
    end
    else
    begin
      st_a <= {link.ready_line, link.off_n_line};
      st_b <= st_a;
    end
  end

  // Unmapped addresses read as zero.
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
      rdata_o <= '0;
    else if (rd_i && addr_i == CSS_REG_CTRL)
      rdata_o <= ctrl;
    else if (rd_i && addr_i == CSS_REG_STAT)
      rdata_o <= {{(CSS_DW-2){1'b0}}, st_b};
    else
      rdata_o <= '0;
  end

  // ----------------------------------------------------------------
  // Card clock divider
  // ----------------------------------------------------------------
  // Divider stops low when disabled so the card sees no runt pulse later.
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i || !ctrl[CSS_CT_CLKEN])
    begin
      div_cnt <= '0;
      clk_out <= 1'b0;
    end
    else if (div_cnt == CSS_DIV_W'(CSS_CLK_HALF - 1))
    begin
      div_cnt <= '0;
      clk_out <= ~clk_out;
    end
    else
      div_cnt <= div_cnt + 1'b1;
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  assign link.chip_select               = ctrl[CSS_CT_CS];
  assign link.supply_cmd_low_voltage_n  = ctrl[CSS_CT_LO_N];
  assign link.supply_cmd_high_voltage_n = ctrl[CSS_CT_HI_N];
  assign link.host_card_reset_in        = ctrl[CSS_CT_RST];
  assign link.host_card_clock_in        = clk_out;
  // Power-down is withheld while either supply command is active.
  assign link.power_down_request = ctrl[CSS_CT_PD] & ctrl[CSS_CT_LO_N] & ctrl[CSS_CT_HI_N];

endmodule

// *** tb/css_link_assertions.sv ***
// Concurrent checks on the link between host controller and sequencer.
`timescale 1ns/10ps
module css_link_assertions #(
  parameter int CHECK_CYC = 1000
)(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic chip_select,
  input wire logic supply_cmd_low_voltage_n,
  input wire logic supply_cmd_high_voltage_n,
  input wire logic off_n_out,
  input wire logic off_n_oe,
  input wire logic ready_out,
  input wire logic ready_oe
);
  // ----------------------------------------------------------------
  // Session age
  // ----------------------------------------------------------------
  logic [15:0] sess_cnt;
  logic        cmds_idle;

  assign cmds_idle = supply_cmd_low_voltage_n & supply_cmd_high_voltage_n;

  // Counts only while selected, since a deselected part holds its old pins.
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i || cmds_idle || !chip_select)
      sess_cnt <= 16'h0000;
    else if (sess_cnt != 16'hffff)
      sess_cnt <= sess_cnt + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  a_oe_lines_pair: assert property ((off_n_oe == ready_oe) && (off_n_oe == $past(chip_select, 2)))
    else $error("status line enables differ");
  a_select_drives: assert property ($rose(chip_select) |-> ##[1:3] off_n_oe)
    else $error("select did not drive status lines");
  a_deselect_floats: assert property ($fell(chip_select) |-> ##[1:3] !off_n_oe)
    else $error("deselect did not release status lines");
  a_ready_after_qual: assert property ($rose(ready_out) |-> sess_cnt >= 16'd800)
    else $error("ready rose too early");
  a_check_deadline: assert property ((sess_cnt == 16'(CHECK_CYC + 8)) |-> (ready_out || !off_n_out))
    else $error("no deactivation at supply check");
  a_idle_no_ready: assert property ((chip_select && cmds_idle) [*6] |-> !ready_out)
    else $error("ready high outside session");
  a_off_stays_low: assert property ((!off_n_out && sess_cnt > 16'd4) |=> !off_n_out)
    else $error("fault indication left during session");
  a_fault_drops_ready: assert property (($fell(off_n_out) && sess_cnt != 0) |-> ##[0:4] !ready_out)
    else $error("ready stayed high after fault");
endmodule

// *** tb/test_card_supply_sequencer.sv ***
// Self-checking bench: host controller and sequencer joined over the link.
`timescale 1ns/10ps
module test_card_supply_sequencer import css_pkg::*;;
  localparam int CHK = 1000;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [CSS_AW-1:0] addr = '0;
  logic [CSS_DW-1:0] wdata = '0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [CSS_DW-1:0] rdata;
  logic [5:0]        dev_in = 6'h08; // {ot, oc, supply ok, vpc, vdd, present}
  logic [1:0]        vsel;
  logic              ven, crst, cclk, lowp;
  int                num_errors = 0;
  int                n_checks = 0;

  // Clock of 25 ns period.
  always #12.5 clk = ~clk;

  // ----------------------------------------------------------------
  // Both ends and the checker
  // ----------------------------------------------------------------
  css_link_if css_link_if_i ();
  css_host css_host_i (.core_clk_i(clk), .reset_n_i(rst_n), .link(css_link_if_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
  css_device #(.CHECK_CYC(CHK)) css_device_i (.core_clk_i(clk), .reset_n_i(rst_n), .link(css_link_if_i),
    .card_present_i(dev_in[0]), .vdd_fault_i(dev_in[1]), .regulator_input_supply_fault_i(dev_in[2]),
    .card_supply_ok_i(dev_in[3]), .over_current_i(dev_in[4]), .over_temp_i(dev_in[5]),
    .vcc_select_o(vsel), .vcc_enable_o(ven), .card_reset_o(crst), .card_clock_o(cclk), .low_power_o(lowp));
  css_link_assertions #(.CHECK_CYC(CHK)) css_link_assertions_i (.core_clk_i(clk), .reset_n_i(rst_n),
    .chip_select(css_link_if_i.chip_select), .supply_cmd_low_voltage_n(css_link_if_i.supply_cmd_low_voltage_n),
    .supply_cmd_high_voltage_n(css_link_if_i.supply_cmd_high_voltage_n), .off_n_out(css_link_if_i.off_n_out),
    .off_n_oe(css_link_if_i.off_n_oe), .ready_out(css_link_if_i.ready_out), .ready_oe(css_link_if_i.ready_oe));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic set_in(input logic [5:0] v);
    @(posedge clk);
    dev_in <= v;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  function automatic logic probe(input int s);
    case (s)
      0: return css_link_if_i.off_n_line;
      1: return css_link_if_i.ready_line;
      2: return ven;
      3: return crst;
      4: return cclk;
      default: return lowp;
    endcase
  endfunction

  // Bounded wait; running out ends the run as a failure.
  task automatic wait_for(input int s, input logic v, input int lim, output int n);
    n = 0;
    while (probe(s) !== v && n < lim)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    // Judge the level itself, so a match on the last allowed cycle still passes.
    if (probe(s) !== v)
    begin
      num_errors++;
      $display("MISMATCH %0t wait on %0d timed out", $time, s);
      stop_test();
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd_reg(CSS_REG_CTRL, CSS_CTRL_RST);
    wr_reg(4'hf, 8'hff);
    rd_reg(4'hf, 8'h00);
    rd_reg(CSS_REG_CTRL, CSS_CTRL_RST);
  endtask

  // Idle line shows presence; a hot die must not disturb it.
  task automatic t_idle();
    int n;
    set_in(6'h28);
    wr_reg(CSS_REG_CTRL, 8'h07);
    wait_for(0, 1'b0, 20, n);
    set_in(6'h29);
    wait_for(0, 1'b1, 20, n);
    // The status register sees the line two flops late.
    repeat (2) @(posedge clk);
    rd_reg(CSS_REG_STAT, 8'h01);
    set_in(6'h09);
  endtask

  task automatic t_act(input logic [7:0] c, input logic [1:0] sel);
    int n;
    wr_reg(CSS_REG_CTRL, c);
    wait_for(2, 1'b1, 40, n);
    chk(8'(vsel), 8'(sel));
    chk(8'(crst), 8'h00);
    wait_for(1, 1'b1, 1000, n);
    chk(8'(n + 4 >= CSS_QUAL_CYC), 8'h01);
    wait_for(3, 1'b1, 8, n);
    wr_reg(CSS_REG_CTRL, (c & 8'hf7) | 8'h10);
    wait_for(3, 1'b0, 8, n);
    wait_for(4, 1'b1, 20, n);
    wait_for(4, 1'b0, 20, n);
    wr_reg(CSS_REG_CTRL, 8'h07);
    wait_for(2, 1'b0, 40, n);
    chk(8'(css_link_if_i.off_n_line), 8'h01);
  endtask

  task automatic t_late();
    int n;
    wr_reg(CSS_REG_CTRL, 8'h03);
    wait_for(2, 1'b1, 40, n);
    repeat (100) @(posedge clk);
    wr_reg(CSS_REG_CTRL, 8'h01);
    repeat (40) @(posedge clk);
    chk(8'(vsel), 8'(CSS_VSEL_5V));
    wr_reg(CSS_REG_CTRL, 8'h07);
    wait_for(2, 1'b0, 40, n);
  endtask

  task automatic t_noready();
    int n;
    set_in(6'h01);
    wr_reg(CSS_REG_CTRL, 8'h03);
    wait_for(0, 1'b0, CHK + 40, n);
    chk(8'(n + 4 >= CHK), 8'h01);
    wait_for(2, 1'b0, 8, n);
    wr_reg(CSS_REG_CTRL, 8'h07);
    set_in(6'h09);
    wait_for(0, 1'b1, 40, n);
  endtask

  task automatic t_fault(input int i, input bit early);
    int n;
    wr_reg(CSS_REG_CTRL, 8'h05);
    wait_for(2, 1'b1, 40, n);
    if (!early)
      wait_for(1, 1'b1, 1000, n);
    set_in(6'h09 ^ (6'h01 << i));
    wait_for(0, 1'b0, 12, n);
    wait_for(2, 1'b0, 12, n);
    wr_reg(CSS_REG_CTRL, 8'h07);
    set_in(6'h09);
    wait_for(0, 1'b1, 40, n);
  endtask

  task automatic t_pd();
    int n;
    wr_reg(CSS_REG_CTRL, 8'h27);
    wait_for(5, 1'b1, 10, n);
    wr_reg(CSS_REG_CTRL, 8'h07);
    wait_for(0, 1'b0, 10, n);
    wait_for(0, 1'b1, CSS_RECOVER_CYC + 20, n);
    chk(8'(n + 4 >= CSS_RECOVER_CYC), 8'h01);
  endtask

  // Deselected part releases its lines and ignores command changes.
  task automatic t_cs();
    int n;
    set_in(6'h08);
    wr_reg(CSS_REG_CTRL, 8'h06);
    wait_for(0, 1'b1, 8, n);
    set_in(6'h09);
    wr_reg(CSS_REG_CTRL, 8'h00);
    repeat (40) @(posedge clk);
    chk(8'(ven), 8'h00);
    wr_reg(CSS_REG_CTRL, 8'h07);
    repeat (40) @(posedge clk);
    chk(8'(ven), 8'h00);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_idle();
    t_act(8'h0b, CSS_VSEL_5V);
    t_act(8'h0d, CSS_VSEL_3V);
    t_act(8'h09, CSS_VSEL_1V8);
    t_late();
    t_noready();
    for (int i = 0; i < 6; i++)
      t_fault(i, 1'b0);
    t_fault(5, 1'b1);
    t_fault(0, 1'b1);
    t_pd();
    t_cs();
    stop_test();
  end
endmodule
